// ===== logic/afecs_pkg.sv
// Constants shared by the cascade serial sequencer.
// Assumes a 16-bit frame-synced serial link shared by up to eight front ends.
// Function
// - 3-bit cascade length in first control register
// - Reset clears length; device acts alone
// - Length code is device count minus one
// - Farthest device sends first, nearest last
// - One extra serial clock between groups
// - Addressing travels inside each control word
// - Address zero accepted, otherwise decremented, passed
// - 16-bit words, frame sync one bit earlier
package afecs_pkg;
   localparam int WORD_W = 16;
   localparam int LEN_W = 3;
   localparam int IDX_W = 4;
   localparam int DATA_W = 8;
   localparam int CNT_W = 5;
   localparam int GAP_W = 8;
   // Control word layout
   localparam int CTRL_FLAG_BIT = 15;
   localparam int ADDR_HI = 14;
   localparam int ADDR_LO = 12;
   localparam int IDX_HI = 11;
   localparam int IDX_LO = 8;
   localparam int DATA_HI = 7;
   localparam int DATA_LO = 0;
   localparam int LEN_LSB = 0;
   localparam logic [IDX_W-1:0] FIRST_CTRL_IDX = 4'h0;
   localparam logic [LEN_W-1:0] LEN_RESET = 3'h0;
   // Serial timing in bit periods
   localparam logic [CNT_W-1:0] SLOT_BITS = 5'h10;
   localparam logic [GAP_W-1:0] SLOT_BITS_G = 8'h10;
   localparam logic [GAP_W-1:0] EXTRA_BITS = 8'h01;
   // Initiator spacing between own starts, minus one
   function automatic logic [GAP_W-1:0] gap_load(input logic [LEN_W-1:0] len);
      gap_load = ({5'h00, len} << 4) + SLOT_BITS_G + EXTRA_BITS - 8'h01;
   endfunction
   function automatic logic is_ctrl(input logic [WORD_W-1:0] w);
      is_ctrl = w[CTRL_FLAG_BIT];
   endfunction
   function automatic logic [2:0] addr_of(input logic [WORD_W-1:0] w);
      addr_of = w[ADDR_HI:ADDR_LO];
   endfunction
endpackage

// ===== logic/afecs_sequencer.sv
// Cascade sequencer of one front end on a shared 16-bit serial link.
// Assumes link_sclk is the serial clock; inputs on the link are launched in that domain.
`timescale 1ns/10ps
module afecs_sequencer #(
   parameter logic [2:0] CHAIN_POS = 3'h0
)(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_sclk,
   input wire logic serial_in_line,
   input wire logic input_frame_sync,
   output logic serial_out_line,
   output logic output_frame_sync,
   input wire logic [afecs_pkg::WORD_W-1:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic ctrl_write,
   output logic [afecs_pkg::IDX_W-1:0] ctrl_index,
   output logic [afecs_pkg::DATA_W-1:0] ctrl_data,
   output logic [afecs_pkg::LEN_W-1:0] cascade_length
);
   import afecs_pkg::*;

   // State of both clock domains
   logic [WORD_W-1:0] rx_shift_reg, rx_shift_next;
   logic [CNT_W-1:0] rx_left_reg, rx_left_next;
   logic [WORD_W-1:0] relay_reg, relay_next;
   logic [WORD_W-1:0] tx_shift_reg, tx_shift_next;
   logic [CNT_W-1:0] tx_left_reg, tx_left_next;
   logic relay_pend_reg, relay_pend_next, out_reg, out_next, fs_reg, fs_next;
   logic [GAP_W-1:0] gap_reg, gap_next;
   logic [LEN_W-1:0] seen_reg, seen_next;
   logic [LEN_W-1:0] len_reg, len_next;
   logic [WORD_W-1:0] own_word_reg, own_word_next;
   logic own_fresh_reg, own_fresh_next, ack_tog_reg, ack_tog_next, ctrl_tog_reg, ctrl_tog_next;
   logic req_s1_reg, req_s2_reg, req_s3_reg;
   logic [IDX_W+DATA_W-1:0] ctrl_hold_reg, ctrl_hold_next;
   logic [GAP_W-1:0] since_reg, since_next;
   logic started_reg, started_next;
   logic [WORD_W-1:0] sample_hold_reg, sample_hold_next;
   logic req_tog_reg, req_tog_next, ack_s1_reg, ack_s2_reg, ctrl_s1_reg, ctrl_s2_reg, ctrl_s3_reg;
   logic ctrl_write_reg, ctrl_write_next, ctrl_edge;
   logic [IDX_W-1:0] ctrl_index_reg, ctrl_index_next;
   logic [DATA_W-1:0] ctrl_data_reg, ctrl_data_next;
   logic [LEN_W-1:0] len_out_reg, len_out_next;
   logic [WORD_W-1:0] rx_word;
   logic rx_done, rx_is_ctrl, accept, tx_free, relay_start, own_start, initiator, req_edge;
   logic [LEN_W-1:0] target;

   assign rx_word = {rx_shift_reg[WORD_W-2:0], serial_in_line};
   assign rx_done = rx_left_reg == 5'h01;
   assign rx_is_ctrl = is_ctrl(rx_word);
   assign accept = rx_done && rx_is_ctrl && (addr_of(rx_word) == 3'h0);
   assign tx_free = tx_left_reg <= 5'h01;
   assign relay_start = tx_free && relay_pend_reg;
   assign initiator = CHAIN_POS >= len_reg;
   assign target = len_reg - CHAIN_POS;
   assign req_edge = req_s2_reg ^ req_s3_reg;
   // Relayed words go before own word; farthest device paces the group
   assign own_start = tx_free && !relay_pend_reg &&
      (initiator ? (own_fresh_reg && gap_reg == 8'h00) : (seen_reg == target));

   always_comb
   begin
      rx_shift_next = rx_shift_reg;
      rx_left_next = rx_left_reg;
      relay_next = relay_reg;
      relay_pend_next = relay_pend_reg;
      tx_shift_next = tx_shift_reg;
      tx_left_next = tx_left_reg;
      out_next = 1'b0;
      gap_next = gap_reg;
      seen_next = seen_reg;
      len_next = len_reg;
      own_word_next = own_word_reg;
      own_fresh_next = own_fresh_reg;
      ack_tog_next = ack_tog_reg;
      ctrl_hold_next = ctrl_hold_reg;
      ctrl_tog_next = ctrl_tog_reg;
      since_next = (since_reg == 8'hff) ? since_reg : since_reg + 8'h01;
      started_next = started_reg;
      // Receive shifter; sync may fall on last bit of previous word
      if (rx_left_reg != 5'h00)
      begin
         rx_shift_next = rx_word;
         rx_left_next = rx_left_reg - 5'h01;
      end
      if (input_frame_sync)
         rx_left_next = SLOT_BITS;
      // Transmit shifter
      if (tx_left_reg != 5'h00)
      begin
         out_next = tx_shift_reg[WORD_W-1];
         tx_shift_next = {tx_shift_reg[WORD_W-2:0], 1'b0};
         tx_left_next = tx_left_reg - 5'h01;
      end
      fs_next = relay_start || own_start;
      if (relay_start)
      begin
         tx_shift_next = relay_reg;
         tx_left_next = SLOT_BITS;
         relay_pend_next = 1'b0;
      end
      else if (own_start)
      begin
         tx_shift_next = own_word_reg;
         tx_left_next = SLOT_BITS;
      end
      if (gap_reg != 8'h00)
         gap_next = gap_reg - 8'h01;
      if (own_start)
      begin
         own_fresh_next = 1'b0;
         seen_next = 3'h0;
         if (initiator)
         begin
            gap_next = gap_load(len_reg);
            since_next = 8'h00;
            started_next = 1'b1;
         end
      end
      // Capture of a finished word
      if (accept)
      begin
         ctrl_hold_next = rx_word[IDX_HI:DATA_LO];
         ctrl_tog_next = ~ctrl_tog_reg;
         if (rx_word[IDX_HI:IDX_LO] == FIRST_CTRL_IDX)
            len_next = rx_word[LEN_LSB+LEN_W-1:LEN_LSB];
      end
      else if (rx_done)
      begin
         relay_pend_next = 1'b1;
         if (rx_is_ctrl)
            relay_next = {rx_word[CTRL_FLAG_BIT], addr_of(rx_word) - 3'h1, rx_word[IDX_HI:DATA_LO]};
         else
         begin
            relay_next = rx_word;
            seen_next = seen_next + 3'h1;
         end
      end
      // New sample from system side; set wins over clear
      if (req_edge)
      begin
         own_word_next = sample_hold_reg;
         own_fresh_next = 1'b1;
         ack_tog_next = req_s2_reg;
      end
   end

   always_ff @(posedge link_sclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rx_shift_reg <= 16'h0000;
         rx_left_reg <= 5'h00;
         relay_reg <= 16'h0000;
         relay_pend_reg <= 1'b0;
         tx_shift_reg <= 16'h0000;
         tx_left_reg <= 5'h00;
         out_reg <= 1'b0;
         fs_reg <= 1'b0;
         gap_reg <= 8'h00;
         seen_reg <= 3'h0;
         len_reg <= LEN_RESET;
         own_word_reg <= 16'h0000;
         own_fresh_reg <= 1'b0;
         req_s1_reg <= 1'b0;
         req_s2_reg <= 1'b0;
         req_s3_reg <= 1'b0;
         ack_tog_reg <= 1'b0;
         ctrl_hold_reg <= 12'h000;
         ctrl_tog_reg <= 1'b0;
         since_reg <= 8'h00;
         started_reg <= 1'b0;
      end
      else
      begin
         rx_shift_reg <= rx_shift_next;
         rx_left_reg <= rx_left_next;
         relay_reg <= relay_next;
         relay_pend_reg <= relay_pend_next;
         tx_shift_reg <= tx_shift_next;
         tx_left_reg <= tx_left_next;
         out_reg <= out_next;
         fs_reg <= fs_next;
         gap_reg <= gap_next;
         seen_reg <= seen_next;
         len_reg <= len_next;
         own_word_reg <= own_word_next;
         own_fresh_reg <= own_fresh_next;
         req_s1_reg <= req_tog_reg;
         req_s2_reg <= req_s1_reg;
         req_s3_reg <= req_s2_reg;
         ack_tog_reg <= ack_tog_next;
         ctrl_hold_reg <= ctrl_hold_next;
         ctrl_tog_reg <= ctrl_tog_next;
         since_reg <= since_next;
         started_reg <= started_next;
      end
   end

   assign serial_out_line = out_reg;
   assign output_frame_sync = fs_reg;

   // System domain: sample handshake and control word delivery
   assign sample_ready = req_tog_reg == ack_s2_reg;
   assign ctrl_edge = ctrl_s2_reg ^ ctrl_s3_reg;

   always_comb
   begin
      sample_hold_next = sample_hold_reg;
      req_tog_next = req_tog_reg;
      ctrl_index_next = ctrl_index_reg;
      ctrl_data_next = ctrl_data_reg;
      len_out_next = len_out_reg;
      ctrl_write_next = ctrl_edge;
      if (sample_valid && sample_ready)
      begin
         sample_hold_next = sample_data;
         req_tog_next = ~req_tog_reg;
      end
      if (ctrl_edge)
      begin
         ctrl_index_next = ctrl_hold_reg[IDX_W+DATA_W-1:DATA_W];
         ctrl_data_next = ctrl_hold_reg[DATA_W-1:0];
         if (ctrl_hold_reg[IDX_W+DATA_W-1:DATA_W] == FIRST_CTRL_IDX)
            len_out_next = ctrl_hold_reg[LEN_LSB+LEN_W-1:LEN_LSB];
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sample_hold_reg <= 16'h0000;
         req_tog_reg <= 1'b0;
         ack_s1_reg <= 1'b0;
         ack_s2_reg <= 1'b0;
         ctrl_s1_reg <= 1'b0;
         ctrl_s2_reg <= 1'b0;
         ctrl_s3_reg <= 1'b0;
         ctrl_write_reg <= 1'b0;
         ctrl_index_reg <= 4'h0;
         ctrl_data_reg <= 8'h00;
         len_out_reg <= LEN_RESET;
      end
      else
      begin
         sample_hold_reg <= sample_hold_next;
         req_tog_reg <= req_tog_next;
         ack_s1_reg <= ack_tog_reg;
         ack_s2_reg <= ack_s1_reg;
         ctrl_s1_reg <= ctrl_tog_reg;
         ctrl_s2_reg <= ctrl_s1_reg;
         ctrl_s3_reg <= ctrl_s2_reg;
         ctrl_write_reg <= ctrl_write_next;
         ctrl_index_reg <= ctrl_index_next;
         ctrl_data_reg <= ctrl_data_next;
         len_out_reg <= len_out_next;
      end
   end

   assign ctrl_write = ctrl_write_reg;
   assign ctrl_index = ctrl_index_reg;
   assign ctrl_data = ctrl_data_reg;
   assign cascade_length = len_out_reg;

   chk_len_reset: assert property (@(posedge link_sclk) $rose(rst_b) |-> len_reg == 3'h0)
      else $error("cascade length not zero after reset");
   chk_len_write: assert property (@(posedge link_sclk) disable iff (!rst_b)
      accept && rx_word[IDX_HI:IDX_LO] == 4'h0 |=> len_reg == $past(rx_word[2:0]))
      else $error("cascade length not taken from control word");
   chk_addr_decrement: assert property (@(posedge link_sclk) disable iff (!rst_b)
      rx_done && rx_is_ctrl && addr_of(rx_word) != 3'h0 |=>
      relay_pend_reg && relay_reg[ADDR_HI:ADDR_LO] == $past(rx_word[ADDR_HI:ADDR_LO]) - 3'h1)
      else $error("forwarded address not decremented");
   chk_relay_exact: assert property (@(posedge link_sclk) disable iff (!rst_b)
      rx_done && !rx_is_ctrl |=> relay_reg == $past(rx_word))
      else $error("relayed data word altered");
   chk_fs_before_bit: assert property (@(posedge link_sclk) disable iff (!rst_b)
      output_frame_sync |-> tx_left_reg == 5'h10 ##1 serial_out_line == $past(tx_shift_reg[15]))
      else $error("first bit does not follow frame sync");
   chk_word_length: assert property (@(posedge link_sclk) disable iff (!rst_b)
      output_frame_sync |-> ##15 tx_left_reg == 5'h01)
      else $error("serial word not 16 bits");
   chk_group_spacing: assert property (@(posedge link_sclk) disable iff (!rst_b)
      own_start && initiator && started_reg |-> since_reg >= gap_load(len_reg))
      else $error("initiator group period too short");
   chk_relay_priority: assert property (@(posedge link_sclk) disable iff (!rst_b)
      own_start |-> !relay_pend_reg && (initiator || (seen_reg == target && tx_left_reg == 5'h01)))
      else $error("own word sent out of turn");
   chk_ctrl_pulse: assert property (@(posedge clk) disable iff (!rst_b)
      ctrl_write |=> !ctrl_write)
      else $error("control write pulse longer than one cycle");
   cov_init_start: cover property (@(posedge link_sclk) disable iff (!rst_b) own_start && initiator);
   cov_own_after_relay: cover property (@(posedge link_sclk) disable iff (!rst_b) own_start && !initiator);
   cov_ctrl_forward: cover property (@(posedge link_sclk) disable iff (!rst_b) relay_start && relay_reg[15]);
   cov_len_set: cover property (@(posedge clk) disable iff (!rst_b) ctrl_write && cascade_length != 3'h0);
endmodule

// ===== test/afecs_host_model.sv
// Host serial port model facing the sequencer link.
// Assumes link_sclk runs free from the front end; all words are 16 bits.
`timescale 1ns/10ps
module afecs_host_model (
   input wire logic link_sclk,
   input wire logic serial_out_line,
   input wire logic output_frame_sync,
   output logic serial_in_line,
   output logic input_frame_sync
);
   logic [15:0] rx_words[$];
   int rx_start[$];
   int cyc = 0;
   int cnt = 0;
   int st = 0;
   logic [15:0] sh;
   initial
   begin
      serial_in_line = 1'b0;
      input_frame_sync = 1'b0;
   end
   // Counts edges after frame sync, so gap bits are ignored
   always @(posedge link_sclk)
   begin
      cyc++;
      if (cnt > 0)
      begin
         sh = {sh[14:0], serial_out_line};
         cnt--;
         if (cnt == 0)
         begin
            rx_words.push_back(sh);
            rx_start.push_back(st);
         end
      end
      if (output_frame_sync === 1'b1)
      begin
         cnt = 16;
         st = cyc;
      end
   end
   // Sync one period before the MSB; line toggles when idle
   task automatic send_word(input logic [15:0] w);
      @(posedge link_sclk);
      #1;
      input_frame_sync = 1'b1;
      serial_in_line = ~serial_in_line;
      for (int i = 15; i >= 0; i--)
      begin
         @(posedge link_sclk);
         #1;
         input_frame_sync = 1'b0;
         serial_in_line = w[i];
      end
      @(posedge link_sclk);
      #1;
      serial_in_line = ~w[0];
   endtask
endmodule

// ===== test/afecs_sequencer_tb_top.sv
// Testbench for one sequencer placed nearest the host.
// Assumes the host model drives the link and collects words sent toward the host.
`timescale 1ns/10ps
module afecs_sequencer_tb_top;
   import afecs_pkg::*;
   logic clk;
   logic link_sclk;
   logic rst_b;
   logic serial_in_line;
   logic input_frame_sync;
   logic serial_out_line;
   logic output_frame_sync;
   logic [WORD_W-1:0] sample_data;
   logic sample_valid;
   logic sample_ready;
   logic ctrl_write;
   logic [IDX_W-1:0] ctrl_index;
   logic [DATA_W-1:0] ctrl_data;
   logic [LEN_W-1:0] cascade_length;
   int n_errors = 0;
   int compares = 0;
   int n_wr = 0;

   afecs_sequencer #(.CHAIN_POS(3'h0)) afecs_sequencer_i (.clk(clk), .rst_b(rst_b), .link_sclk(link_sclk),
      .serial_in_line(serial_in_line), .input_frame_sync(input_frame_sync), .serial_out_line(serial_out_line),
      .output_frame_sync(output_frame_sync), .sample_data(sample_data), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .ctrl_write(ctrl_write), .ctrl_index(ctrl_index), .ctrl_data(ctrl_data),
      .cascade_length(cascade_length));
   afecs_host_model afecs_host_model_i (.link_sclk(link_sclk), .serial_out_line(serial_out_line),
      .output_frame_sync(output_frame_sync), .serial_in_line(serial_in_line),
      .input_frame_sync(input_frame_sync));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Link clock, phase offset from clk
   initial
   begin
      link_sclk = 1'b0;
      #37;
      forever #80 link_sclk = ~link_sclk;
   end
   always @(posedge clk)
      if (ctrl_write === 1'b1)
         n_wr++;

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask
   task automatic results();
      $display("Counts: %0d compares, %0d mismatches", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic hang(input string nm);
      $display("Error %s expected done seen timeout", nm);
      n_errors++;
      results();
   endtask
   function automatic logic [15:0] rxw(input int i);
      return afecs_host_model_i.rx_words[i];
   endfunction
   function automatic logic [15:0] gap();
      return 16'(afecs_host_model_i.rx_start[1] - afecs_host_model_i.rx_start[0]);
   endfunction
   task automatic clr();
      afecs_host_model_i.rx_words.delete();
      afecs_host_model_i.rx_start.delete();
   endtask
   task automatic snd(input logic [15:0] w);
      afecs_host_model_i.send_word(w);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge link_sclk);
      @(negedge clk);
   endtask
   task automatic wait_rx(input int n);
      for (int k = 0; afecs_host_model_i.rx_words.size() < n; k++)
      begin
         @(posedge link_sclk);
         if (k > 200)
            hang("rx_words");
      end
   endtask
   task automatic put_sample(input logic [15:0] w);
      @(negedge clk);
      for (int k = 0; sample_ready !== 1'b1; k++)
      begin
         @(negedge clk);
         if (k > 200)
            hang("sample_ready");
      end
      sample_data = w;
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
   endtask

   task automatic t_reset();
      check("cascade_length", 16'h0000, {13'h0000, cascade_length});
      check("sample_ready", 16'h0001, {15'h0000, sample_ready});
      check("frame_sync_out", 16'h0000, {15'h0000, output_frame_sync});
      check("ctrl_write", 16'h0000, {15'h0000, ctrl_write});
      $display("Test reset done");
   endtask
   task automatic t_length();
      int w0;
      for (int c = 7; c >= 0; c--)
      begin
         w0 = n_wr;
         snd({13'h1000, c[2:0]});
         idle(8);
         check("cascade_length", {13'h0000, c[2:0]}, {13'h0000, cascade_length});
         check("ctrl_write_count", 16'h0001, 16'(n_wr - w0));
      end
      snd(16'h85a7);
      idle(8);
      check("ctrl_word", 16'h05a7, {4'h0, ctrl_index, ctrl_data});
      check("cascade_length", 16'h0000, {13'h0000, cascade_length});
      check("accepted_not_sent", 16'h0000, 16'(afecs_host_model_i.rx_words.size()));
      $display("Test length done");
   endtask
   task automatic t_forward();
      clr();
      for (int a = 1; a < 8; a++)
         snd({1'b1, a[2:0], 12'h3a5});
      wait_rx(7);
      for (int a = 1; a < 8; a++)
         check("forwarded_word", {1'b1, 3'(a - 1), 12'h3a5}, rxw(a - 1));
      $display("Test forward done");
   endtask
   task automatic t_turns();
      clr();
      put_sample(16'h1234);
      put_sample(16'h0bcd);
      wait_rx(2);
      check("own_word", 16'h1234, rxw(0));
      check("own_word", 16'h0bcd, rxw(1));
      check("own_spacing", 16'h0011, gap());
      snd(16'h8001);
      idle(8);
      clr();
      put_sample(16'h0c3e);
      idle(4);
      snd(16'h7e81);
      wait_rx(2);
      check("relayed_first", 16'h7e81, rxw(0));
      check("own_last", 16'h0c3e, rxw(1));
      check("turn_spacing", 16'h0010, gap());
      $display("Test turns done");
   endtask

   initial
   begin
      rst_b = 1'b0;
      sample_data = 16'h0000;
      sample_valid = 1'b0;
      repeat (5) @(negedge clk);
      t_reset();
      rst_b = 1'b1;
      idle(2);
      t_length();
      t_forward();
      t_turns();
      results();
   end
endmodule
